// ==== hdl/gpio_cfg.svh ====
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

`define A_DATA5 8'h00
`define A_DATA6 8'h04
`define A_DIR6 8'h14
`define A_DIR8 8'h1C
`define A_FUNC 8'h20
`define A_PDOWN 8'h24
`define A_ODRAIN 8'h28
`define A_PUP 8'h2C
`define A_MASK2 8'h30
`define A_MASK1 8'h34
`define A_CTRL 8'h38
`define A_FLAGS 8'h3C
`define A_WAKE 8'h40
`define A_CMD 8'h44
`define A_STATUS 8'h48

`define RST_DIR 32'hFFFF_FFFF
`define RST_DATA 32'h0000_0000
`define RST_CFG 8'h00

`define M_FUNC 8'hCF
`define M_ODRAIN 8'h0F
`define M_PUP 8'h0F
`define M_MASK2 8'h30
`define M_MASK1 8'hC7

`define B_WDT_RUN 7
`define B_FUNC_SEL 6
`define B_EXT_IE 2
`define B_CHG_IE 1
`define B_EDGE 7
`define B_GIE 6
`define B_WAKE_CHG 6
`define B_EXT_FLAG 2
`define B_CHG_FLAG 1
`define B_CMD_ON 0
`define B_CMD_OFF 1
`define B_CMD_SLEEP 2

`define VEC_EXT 11'h003
`define VEC_CHG 11'h006

`endif

// ==== hdl/gpio_pkg.sv ====
package gpio_pkg;

    typedef struct packed {
        logic [31:0] out;
        logic [31:0] oe_n;
        logic [31:0] pu_en;
        logic [31:0] pd_en;
    } pin_drive_t;

    typedef struct packed {
        logic [31:0] data;
        logic [31:0] dir;
        logic [7:0] func;
        logic [7:0] pdown;
        logic [7:0] odrain;
        logic [7:0] pup;
        logic [7:0] mask2;
        logic [7:0] mask1;
        logic edge_sel;
        logic gie;
        logic ext_flag;
        logic chg_flag;
        logic wake_chg;
        logic sleeping;
        logic resume_next;
        logic wake_pulse;
        logic [3:0] chg_ref;
        logic ext_prev;
        logic act;
        logic wr;
        logic [7:0] addr;
        logic [7:0] rdata;
        logic irq;
        logic [10:0] vec;
    } state_t;

endpackage

// ==== hdl/pin_sync.sv ====
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 32
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;

    sync_state_t s, n;

    always_comb begin
        n.s1 = d;
        n.s2 = s.s1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign q = s.s2;
endmodule

// ==== hdl/port_config_and_change_wakeup.sv ====
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "gpio_cfg.svh"
module port_config_and_change_wakeup
    import gpio_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Port pins: 5 in bits 7..0, 6 in 15..8, 7 in 23..16, 8 in 31..24.
    input wire logic [31:0] pin_in,
    output gpio_pkg::pin_drive_t pins,
    // Core side.
    output logic irq_req,
    output logic [10:0] irq_vector,
    output logic wake_pulse,
    output logic sleeping,
    output logic watchdog_run_enable
);
    import gpio_pkg::*;

    state_t s, n;
    logic [31:0] lv;
    logic [3:0] pin6;
    logic ext_in;
    logic addr_phase;

    // Every pin level passes two flip-flops before any logic sees it.
    pin_sync #(
        .W(32)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(pin_in),
        .q(lv)
    );

    assign pin6 = lv[11:8];
    assign ext_in = lv[8];
    assign addr_phase = hsel && hready && htrans[1];

    function automatic logic [7:0] reg_read(input state_t t,
                                             input logic [7:0] a,
                                             input logic [31:0] lvl);
        logic [4:0] b;
        b = {a[3:2], 3'h0};
        reg_read = 8'h00;
        if (a <= `A_DIR8 && a[1:0] == 2'h0) begin
            // Data addresses return pin levels, so port 6 pin 0 reads as the
            // interrupt pin too.
            reg_read = a[4] ? t.dir[b +: 8] : lvl[b +: 8];
        end else begin
            case (a)
                `A_FUNC: reg_read = t.func;
                `A_PDOWN: reg_read = t.pdown;
                `A_ODRAIN: reg_read = t.odrain;
                `A_PUP: reg_read = t.pup;
                `A_MASK2: reg_read = t.mask2;
                `A_MASK1: reg_read = t.mask1;
                `A_CTRL: reg_read = {t.edge_sel, t.gie, 6'h00};
                `A_FLAGS: reg_read = {5'h00, t.ext_flag, t.chg_flag, 1'b0};
                `A_WAKE: reg_read = {1'b0, t.wake_chg, 6'h00};
                `A_STATUS: reg_read = {6'h00, t.resume_next, t.sleeping};
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    always_comb begin
        logic [4:0] b;
        logic [7:0] w;
        b = {s.addr[3:2], 3'h0};
        w = hwdata[7:0];
        n = s;
        n.act = 1'b0;
        n.wake_pulse = 1'b0;
        // Data phase of a write.
        if (s.act && s.wr) begin
            if (s.addr <= `A_DIR8 && s.addr[1:0] == 2'h0) begin
                if (s.addr[4]) begin
                    n.dir[b +: 8] = w;
                end else begin
                    n.data[b +: 8] = w;
                end
            end else begin
                case (s.addr)
                    `A_FUNC: n.func = w & `M_FUNC;
                    `A_PDOWN: n.pdown = w;
                    `A_ODRAIN: n.odrain = w & `M_ODRAIN;
                    `A_PUP: n.pup = w & `M_PUP;
                    `A_MASK2: n.mask2 = w & `M_MASK2;
                    `A_MASK1: n.mask1 = w & `M_MASK1;
                    `A_CTRL: n.edge_sel = w[`B_EDGE];
                    `A_FLAGS: begin
                        if (w[`B_EXT_FLAG]) begin
                            n.ext_flag = 1'b0;
                        end
                        if (w[`B_CHG_FLAG]) begin
                            n.chg_flag = 1'b0;
                        end
                    end
                    `A_WAKE: n.wake_chg = w[`B_WAKE_CHG];
                    `A_CMD: begin
                        // Off wins when both instruction strobes are written.
                        if (w[`B_CMD_ON]) begin
                            n.gie = 1'b1;
                        end
                        if (w[`B_CMD_OFF]) begin
                            n.gie = 1'b0;
                        end
                        if (w[`B_CMD_SLEEP]) begin
                            n.sleeping = 1'b1;
                            n.resume_next = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
        // Hardware sets come after software clears so that they win.
        if (pin6 != s.chg_ref) begin
            n.chg_flag = 1'b1;
        end
        if (s.func[`B_FUNC_SEL] &&
            ((!s.edge_sel && ext_in && !s.ext_prev) ||
             (s.edge_sel && !ext_in && s.ext_prev))) begin
            n.ext_flag = 1'b1;
        end
        n.ext_prev = ext_in;
        // Change wake-up; with the change mask clear the core carries on
        // after the sleep instruction instead of taking the vector.
        if (s.sleeping && s.wake_chg && s.chg_flag) begin
            n.sleeping = 1'b0;
            n.wake_pulse = 1'b1;
            n.resume_next = !(s.gie && s.mask1[`B_CHG_IE]);
        end
        // Address phase; reads other than data reads see any write finishing in this cycle.
        if (addr_phase) begin
            n.act = 1'b1;
            n.wr = hwrite;
            n.addr = haddr[7:0];
            if (!hwrite) begin
                if (haddr[7:0] == `A_DATA6) begin
                    n.chg_ref = pin6;
                end
                n.rdata = reg_read(n, haddr[7:0], lv);
            end
        end
        n.irq = n.gie &&
                ((n.ext_flag && n.mask1[`B_EXT_IE]) ||
                 (n.chg_flag && n.mask1[`B_CHG_IE]));
        n.vec = (n.ext_flag && n.mask1[`B_EXT_IE]) ? `VEC_EXT
                                                    : `VEC_CHG;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.dir <= `RST_DIR;
            s.data <= `RST_DATA;
            s.func <= `RST_CFG;
            s.pdown <= `RST_CFG;
            s.odrain <= `RST_CFG;
            s.pup <= `RST_CFG;
            s.mask2 <= `RST_CFG;
            s.mask1 <= `RST_CFG;
            s.vec <= `VEC_CHG;
        end else begin
            s <= n;
        end
    end

    // Per-pin drive, open-drain and pull selection.
    generate
        for (genvar i = 0; i < 32; i++) begin : g_pin
            logic od;
            if (i >= 8 && i < 12) begin : g_p6
                assign od = s.odrain[i-8];
                assign pins.pu_en[i] = ~s.pup[i-8];
                assign pins.pd_en[i] = ~s.pdown[i-4];
            end else if (i < 4) begin : g_p5
                assign od = 1'b0;
                assign pins.pu_en[i] = 1'b0;
                assign pins.pd_en[i] = ~s.pdown[i];
            end else begin : g_none
                assign od = 1'b0;
                assign pins.pu_en[i] = 1'b0;
                assign pins.pd_en[i] = 1'b0;
            end
            assign pins.out[i] = s.data[i];
            // An open-drain pin lets go of the wire when driving a one.
            assign pins.oe_n[i] = s.dir[i] | (od & s.data[i]);
        end
    endgenerate

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = {24'h000000, s.rdata};
    assign irq_req = s.irq;
    assign irq_vector = s.vec;
    assign wake_pulse = s.wake_pulse;
    assign sleeping = s.sleeping;
    assign watchdog_run_enable = s.func[`B_WDT_RUN];

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_dir_write;
        s.act && s.wr && s.addr == `A_DIR6
        |=> s.dir[15:8] == $past(hwdata[7:0]) ##1
            pins.oe_n[8] == (s.dir[8] | (s.odrain[0] & s.data[8]));
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("port 6 direction write not applied");

    property p_dir_read;
        addr_phase && !hwrite && haddr[7:0] == `A_DIR6 && !(s.act && s.wr)
        |=> hrdata[7:0] == s.dir[15:8];
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction read returned wrong value");

    property p_func_block;
        !s.func[`B_FUNC_SEL] |=> !$rose(s.ext_flag);
    endproperty
    a_func_block: assert property (p_func_block)
        else $error("external flag set while path blocked");

    property p_edge;
        s.func[`B_FUNC_SEL] && !s.edge_sel && ext_in && !s.ext_prev
        |=> s.ext_flag;
    endproperty
    a_edge: assert property (p_edge)
        else $error("rising edge not captured");

    property p_opendrain;
        s.odrain[0] && s.data[8] && !s.dir[8] |-> pins.oe_n[8];
    endproperty
    a_opendrain: assert property (p_opendrain)
        else $error("open-drain pin drove high");

    property p_pulls;
        pins.pu_en[8] == !s.pup[0] && pins.pd_en[15:12] == 4'h0 &&
        pins.pd_en[8] == !s.pdown[4] && pins.pd_en[0] == !s.pdown[0];
    endproperty
    a_pulls: assert property (p_pulls)
        else $error("pull enable mapping wrong");

    property p_gate;
        irq_req |-> s.gie && (s.ext_flag && s.mask1[2] ||
                              s.chg_flag && s.mask1[1]);
    endproperty
    a_gate: assert property (p_gate)
        else $error("request without mask and global enable");

    property p_vector;
        irq_req && !(s.ext_flag && s.mask1[2]) |-> irq_vector == 11'h006;
    endproperty
    a_vector: assert property (p_vector)
        else $error("change vector wrong");

    property p_change;
        pin6 != s.chg_ref |=> s.chg_flag;
    endproperty
    a_change: assert property (p_change)
        else $error("port 6 change missed");

    property p_resume;
        s.sleeping && s.wake_chg && s.chg_flag && !s.mask1[1]
        |=> wake_pulse && s.resume_next && !sleeping;
    endproperty
    a_resume: assert property (p_resume)
        else $error("wake without next-instruction resume");

    property p_unused;
        s.odrain[7:4] == 4'h0 && s.pup[7:4] == 4'h0 &&
        s.func[5:4] == 2'h0 && s.mask1[5:3] == 3'h0 && s.mask2[7:6] == 2'h0;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused bit held a one");
endmodule

// ==== verif/pin_board.sv ====
`timescale 1ns/100ps
module pin_board
    import gpio_pkg::*;
(
    // Clock.
    input wire logic hclk,
    // Device drive and board drive.
    input gpio_pkg::pin_drive_t pins,
    input wire logic [31:0] ext_lvl,
    input wire logic [31:0] ext_en,
    // Resolved pin levels.
    output logic [31:0] level
);
    // A floating pin wanders each cycle so no stale level is trusted.
    logic [31:0] flt_r = 32'h5555_5555;
    always @(posedge hclk) begin
        flt_r <= ~flt_r;
    end
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (ext_en[i])
                level[i] = ext_lvl[i];
            else if (!pins.oe_n[i])
                level[i] = pins.out[i];
            else if (pins.pu_en[i] && !pins.pd_en[i])
                level[i] = 1'b1;
            else if (pins.pd_en[i] && !pins.pu_en[i])
                level[i] = 1'b0;
            else
                level[i] = flt_r[i];
        end
    end
endmodule

// ==== verif/port_config_and_change_wakeup_test.sv ====
`timescale 1ns/100ps
`include "gpio_cfg.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module port_config_and_change_wakeup_test;
    import gpio_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, irq_req, wake_pulse, sleeping, wdt_on;
    logic [31:0] hrdata, level, rd;
    logic [10:0] irq_vector;
    pin_drive_t pins;
    logic [31:0] ext_lvl = 32'h0;
    logic [31:0] ext_en = 32'h0000_0F0F;
    logic woke = 1'b0;
    int failures = 0;
    int cmp_count = 0;

    port_config_and_change_wakeup DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pin_in(level), .pins(pins), .irq_req(irq_req),
        .irq_vector(irq_vector), .wake_pulse(wake_pulse),
        .sleeping(sleeping), .watchdog_run_enable(wdt_on));
    pin_board board (.hclk(hclk), .pins(pins), .ext_lvl(ext_lvl),
        .ext_en(ext_en), .level(level));

    initial begin
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (wake_pulse === 1'b1)
            woke <= 1'b1;
    end

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(rd, {24'h0, e})
    endtask
    task automatic pin(input int i, input logic v);
        @(posedge hclk);
        woke <= 1'b0;
        ext_lvl[i] <= v;
    endtask
    task automatic wait8();
        repeat (8) @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic t_ports();
        for (int i = 0; i < 4; i++) begin
            `CHK(pins.oe_n[8*i+:8], 8'hFF)
            rdchk(8'(8'h10 + 4 * i), 8'hFF);
            wr(8'(4 * i), 8'(8'hA5 ^ i));
            wr(8'(8'h10 + 4 * i), 8'hF0);
            rdchk(8'(8'h10 + 4 * i), 8'hF0);
        end
        @(negedge hclk);
        `CHK(pins.oe_n, 32'hF0F0_F0F0)
        `CHK(pins.out, 32'hA6A7_A4A5)
        // Board drives the input nibble of port 5; the device drives the rest.
        @(posedge hclk);
        ext_en <= 32'h0000_0FF0;
        ext_lvl <= 32'h0000_00A0;
        wait8();
        rdchk(`A_DATA5, 8'hA5);
        for (int i = 0; i < 4; i++)
            wr(8'(8'h10 + 4 * i), 8'hFF);
        @(posedge hclk);
        ext_en <= 32'h0000_0F0F;
        ext_lvl <= 32'h0000_0000;
    endtask

    task automatic t_cfg();
        wr(`A_FUNC, 8'hFF);
        wr(`A_PDOWN, 8'hFF);
        wr(`A_ODRAIN, 8'hFF);
        wr(`A_PUP, 8'hFF);
        wr(`A_MASK1, 8'hFF);
        wr(`A_MASK2, 8'hFF);
        rdchk(`A_FUNC, 8'hCF);
        rdchk(`A_PDOWN, 8'hFF);
        rdchk(`A_ODRAIN, 8'h0F);
        rdchk(`A_PUP, 8'h0F);
        rdchk(`A_MASK1, 8'hC7);
        rdchk(`A_MASK2, 8'h30);
        `CHK(wdt_on, 1'b1)
        wr(`A_FUNC, 8'h00);
        wr(`A_PDOWN, 8'h0F);
        wr(`A_PUP, 8'h0A);
        wr(`A_ODRAIN, 8'h01);
        wr(`A_DIR6, 8'hFE);
        wr(`A_DATA6, 8'h01);
        @(negedge hclk);
        `CHK(pins.pd_en[11:0], 12'hF00)
        `CHK(pins.pu_en[11:8], 4'h5)
        `CHK(pins.oe_n[8], 1'b1)
        `CHK(wdt_on, 1'b0)
        wr(`A_DATA6, 8'h00);
        @(negedge hclk);
        `CHK(pins.oe_n[8], 1'b0)
        wr(`A_ODRAIN, 8'h00);
        wr(`A_DIR6, 8'hFF);
        wr(`A_FUNC, 8'h00);
        wr(`A_MASK1, 8'h00);
        wr(`A_MASK2, 8'h00);
        wr(`A_PDOWN, 8'h00);
        wr(`A_PUP, 8'h00);
    endtask

    // Port 6 pin 0 keeps its direction bit at one throughout.
    task automatic t_ext();
        wr(`A_CMD, 8'h01);
        wr(`A_MASK1, 8'h04);
        wr(`A_FLAGS, 8'h06);
        pin(8, 1'b1);
        wait8();
        `CHK(irq_req, 1'b0)
        bus(1'b0, `A_FLAGS, 8'h00);
        `CHK(rd[2], 1'b0)
        pin(8, 1'b0);
        wr(`A_FUNC, 8'h40);
        wr(`A_FLAGS, 8'h06);
        pin(8, 1'b1);
        wait8();
        `CHK(irq_req, 1'b1)
        `CHK(irq_vector, `VEC_EXT)
        bus(1'b0, `A_DATA6, 8'h00);
        `CHK(rd[0], 1'b1)
        wr(`A_CMD, 8'h02);
        wait8();
        `CHK(irq_req, 1'b0)
        wr(`A_CMD, 8'h01);
        wr(`A_MASK1, 8'h00);
        wait8();
        `CHK(irq_req, 1'b0)
        wr(`A_CTRL, 8'h80);
        wr(`A_FLAGS, 8'h06);
        wr(`A_MASK1, 8'h04);
        pin(8, 1'b0);
        wait8();
        `CHK(irq_req, 1'b1)
        wr(`A_FLAGS, 8'h06);
        pin(8, 1'b1);
        wait8();
        `CHK(irq_req, 1'b0)
        wr(`A_CTRL, 8'h00);
        wr(`A_FUNC, 8'h00);
    endtask

    task automatic t_chg();
        bus(1'b0, `A_DATA6, 8'h00);
        wr(`A_CMD, 8'h01);
        wr(`A_MASK1, 8'h02);
        wr(`A_FLAGS, 8'h06);
        wait8();
        `CHK(irq_req, 1'b0)
        pin(9, 1'b1);
        wait8();
        `CHK(irq_req, 1'b1)
        `CHK(irq_vector, `VEC_CHG)
        bus(1'b0, `A_DATA6, 8'h00);
        wr(`A_FLAGS, 8'h06);
        wait8();
        `CHK(irq_req, 1'b0)
        wr(`A_MASK1, 8'h00);
        pin(10, 1'b1);
        wait8();
        `CHK(irq_req, 1'b0)
        bus(1'b0, `A_FLAGS, 8'h00);
        `CHK(rd[1], 1'b1)
    endtask

    task automatic t_sleep();
        for (int c = 0; c < 2; c++) begin
            wr(`A_FUNC, 8'h00);
            bus(1'b0, `A_DATA6, 8'h00);
            wr(`A_CMD, 8'h01);
            wr(`A_MASK1, c ? 8'h00 : 8'h02);
            wr(`A_WAKE, 8'h40);
            wr(`A_FLAGS, 8'h06);
            wr(`A_CMD, 8'h04);
            wait8();
            `CHK(sleeping, 1'b1)
            pin(11, ~ext_lvl[11]);
            wait8();
            `CHK(woke, 1'b1)
            `CHK(sleeping, 1'b0)
            `CHK(irq_req, c == 0)
            bus(1'b0, `A_STATUS, 8'h00);
            `CHK(rd[1], c == 1)
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_ports();
        t_cfg();
        t_ext();
        t_chg();
        t_sleep();
        report_and_stop();
    end
endmodule
